// ---- tcv_pkg.sv ----
// Constants for the two-train trip coincidence and interlock block.
// Assumes a single 100 MHz clock domain and an Avalon-MM word-addressed slave.
`default_nettype none
package tcv_pkg;
	// Register word indices
	localparam logic [2:0] REG_CMD       = 3'h0;
	localparam logic [2:0] REG_CHAN_BYP  = 3'h1;
	localparam logic [2:0] REG_STATUS    = 3'h2;
	localparam logic [2:0] REG_IRQ_STAT  = 3'h3;
	localparam logic [2:0] REG_IRQ_MASK  = 3'h4;
	// Command register fields, two bits each, train A in the low bit
	localparam int CMD_LO_BYP_POS  = 0;
	localparam int CMD_IR_BLK_POS  = 2;
	localparam int CMD_SR_BYP_POS  = 4;
	localparam int CMD_SR_REIN_POS = 6;
	localparam int CMD_MAN_TRIP_POS = 8;
	localparam int CMD_RESET_POS   = 10;
	// Channel bypass register fields
	localparam int CHB_IR_POS = 0;
	localparam int CHB_SR_POS = 2;
	// Status register fields, two bits each
	localparam int ST_TRIP_POS   = 0;
	localparam int ST_LO_BYP_POS = 2;
	localparam int ST_IR_BLK_POS = 4;
	localparam int ST_SR_BYP_POS = 6;
	localparam int ST_P10_POS    = 8;
	localparam int ST_P6_POS     = 10;
	localparam int ST_DEMAND_POS = 12;
	// Interrupt event bits
	localparam int IRQ_TRIP_POS = 0;
	localparam int IRQ_REJ_POS  = 2;
	// Coincidence thresholds
	localparam logic [2:0] VOTE_TRIP  = 3'h2;
	localparam logic [2:0] VOTE_CLEAR = 3'h3;
	// Reset values
	localparam logic [1:0] RST_TRIP     = 2'h3;
	localparam logic [3:0] RST_CHAN_BYP = 4'h0;
	localparam logic [3:0] RST_IRQ_MASK = 4'h0;
	localparam logic [31:0] RST_RDATA   = 32'h0;
endpackage
`default_nettype wire

// ---- tcv_voter.sv ----
// Two-train trip coincidence voter with bypass and block interlocks.
// Bistables arrive synchronous to sys_clk, train A in the low half of each bus ([3:0] or [1:0]), train B in the high half ([7:4] or [3:2]).
//
// The Avalon-MM register port and the address map are this design's own decisions.
`default_nettype none
module tcv_voter (
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic [2:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	output logic             irq,
	input  wire logic [7:0]  pr_high_bist,
	input  wire logic [7:0]  pr_low_bist,
	input  wire logic [7:0]  pr_rate_bist,
	input  wire logic [7:0]  pr_p10_bist,
	input  wire logic [3:0]  ir_trip_bist,
	input  wire logic [3:0]  ir_p6_bist,
	input  wire logic [3:0]  sr_trip_bist,
	output logic             train_a_trip_breaker_uv_hold,
	output logic             train_a_trip_breaker_shunt,
	output logic             train_b_trip_breaker_uv_hold,
	output logic             train_b_trip_breaker_shunt,
	output logic             turbine_trip,
	output logic             chan_bypass_annunc
);

	typedef struct packed {
		logic        ack;
		logic [31:0] rdata;
		logic [3:0]  chan_byp;
		logic [3:0]  irq_stat;
		logic [3:0]  irq_mask;
		logic [1:0]  lo_byp;
		logic [1:0]  ir_blk;
		logic [1:0]  sr_byp;
		logic [1:0]  demand;
		logic [1:0]  trip;
		logic [1:0]  hold;
		logic [1:0]  shunt;
		logic        turb;
		logic        annunc;
		logic        irq_out;
	} tcv_state_s;

	tcv_state_s state_ff;
	tcv_state_s nxt_state;

	// Number of set bits in a four-channel group
	function automatic logic [2:0] tcv_count4(input logic [3:0] v);
		tcv_count4 = {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]};
	endfunction

	function automatic logic tcv_two_of_four(input logic [3:0] v);
		tcv_two_of_four = tcv_count4(v) >= tcv_pkg::VOTE_TRIP;
	endfunction

	function automatic logic tcv_three_of_four(input logic [3:0] v);
		tcv_three_of_four = tcv_count4(v) >= tcv_pkg::VOTE_CLEAR;
	endfunction

	// Write accepted this cycle to the given word
	function automatic logic tcv_wr_hit(input logic en, input logic [2:0] addr, input logic [2:0] target);
		tcv_wr_hit = en && (addr == target);
	endfunction

	// Next value of a permissive-gated bypass or block bit.
	// Auto-clear wins, so a request cannot hold a bypass below P-10.
	function automatic logic tcv_next_gated(input logic cur, input logic clear, input logic request,
		input logic permit);
		logic nxt;
		nxt = cur;
		if (clear) begin
			nxt = 1'b0;
		end else if (request && permit) begin
			nxt = 1'b1;
		end
		tcv_next_gated = nxt;
	endfunction

	// Next value of a train's source range manual bypass
	function automatic logic tcv_next_src_byp(input logic cur, input logic p6_on, input logic rein,
		input logic p10_on, input logic request);
		logic nxt;
		nxt = cur;
		if (!p6_on) begin
			nxt = 1'b0;
		end else if (rein && !p10_on) begin
			nxt = 1'b0;
		end else if (request) begin
			nxt = 1'b1;
		end
		tcv_next_src_byp = nxt;
	endfunction

	logic        req;
	logic        wr_en;
	logic [31:0] cmd;
	logic [1:0]  p10;
	logic [1:0]  p10_clear;
	logic [1:0]  p6;
	logic [1:0]  auto_dem;
	logic [1:0]  sr_eff_byp;
	logic [3:0]  irq_ev;
	logic [31:0] status_word;

	always_comb begin
		logic [3:0] grp;
		logic [1:0] ir_ch;
		logic [1:0] sr_ch;
		logic       f_high;
		logic       f_low;
		logic       f_rate;
		logic       f_ir;
		logic       f_sr;
		logic       man;
		logic       rst_req;
		logic [3:0] irq_clr;
		grp = 4'h0;
		irq_clr = 4'h0;
		ir_ch = 2'h0;
		sr_ch = 2'h0;
		f_high = 1'b0;
		f_low = 1'b0;
		f_rate = 1'b0;
		f_ir = 1'b0;
		f_sr = 1'b0;
		man = 1'b0;
		rst_req = 1'b0;
		nxt_state = state_ff;

		// Bus slave: one wait cycle, then accept
		req = avs_read | avs_write;
		wr_en = avs_write & state_ff.ack;
		nxt_state.ack = req & ~state_ff.ack;
		cmd = tcv_wr_hit(wr_en, avs_address, tcv_pkg::REG_CMD) ? avs_writedata : 32'h0;

		// Plain register writes; status and unmapped words ignore writes
		if (wr_en) begin
			case (avs_address)
				tcv_pkg::REG_CHAN_BYP: begin
					nxt_state.chan_byp = avs_writedata[3:0];
				end
				tcv_pkg::REG_IRQ_MASK: begin
					nxt_state.irq_mask = avs_writedata[3:0];
				end
				default: begin
					nxt_state.chan_byp = state_ff.chan_byp;
				end
			endcase
		end

		irq_ev = 4'h0;
		p10 = 2'h0;
		p10_clear = 2'h0;
		p6 = 2'h0;
		auto_dem = 2'h0;
		sr_eff_byp = 2'h0;

		for (int t = 0; t < 2; t++) begin
			// Permissives formed inside each train
			grp = pr_p10_bist[t*4 +: 4];
			p10[t] = tcv_two_of_four(grp);
			p10_clear[t] = tcv_three_of_four(~grp);
			p6[t] = |ir_p6_bist[t*2 +: 2];

			// Low power range setting bypass
			nxt_state.lo_byp[t] = tcv_next_gated(state_ff.lo_byp[t], p10_clear[t],
				cmd[tcv_pkg::CMD_LO_BYP_POS + t], p10[t]);

			// Intermediate range block
			nxt_state.ir_blk[t] = tcv_next_gated(state_ff.ir_blk[t], p10_clear[t],
				cmd[tcv_pkg::CMD_IR_BLK_POS + t], p10[t]);

			// Source range manual bypass
			nxt_state.sr_byp[t] = tcv_next_src_byp(state_ff.sr_byp[t], p6[t],
				cmd[tcv_pkg::CMD_SR_REIN_POS + t], p10[t], cmd[tcv_pkg::CMD_SR_BYP_POS + t]);
			sr_eff_byp[t] = state_ff.sr_byp[t] | p10[t];

			// Channel test bypasses remove single channels from the vote
			ir_ch = ir_trip_bist[t*2 +: 2] & ~state_ff.chan_byp[tcv_pkg::CHB_IR_POS +: 2];
			sr_ch = sr_trip_bist[t*2 +: 2] & ~state_ff.chan_byp[tcv_pkg::CHB_SR_POS +: 2];

			f_high = tcv_two_of_four(pr_high_bist[t*4 +: 4]);
			f_low = tcv_two_of_four(pr_low_bist[t*4 +: 4]) & ~state_ff.lo_byp[t];
			f_rate = tcv_two_of_four(pr_rate_bist[t*4 +: 4]);
			f_ir = (|ir_ch) & ~state_ff.ir_blk[t];
			f_sr = (|sr_ch) & ~sr_eff_byp[t];
			auto_dem[t] = f_high | f_low | f_rate | f_ir | f_sr;

			man = cmd[tcv_pkg::CMD_MAN_TRIP_POS + t];
			rst_req = cmd[tcv_pkg::CMD_RESET_POS + t];
			nxt_state.demand[t] = auto_dem[t] | man;

			// Latched trip, reset only once the cause has gone
			if (state_ff.demand[t]) begin
				nxt_state.trip[t] = 1'b1;
			end else if (rst_req && !auto_dem[t] && !man) begin
				nxt_state.trip[t] = 1'b0;
			end
			irq_ev[tcv_pkg::IRQ_TRIP_POS + t] = state_ff.demand[t] & ~state_ff.trip[t];
			irq_ev[tcv_pkg::IRQ_REJ_POS + t] = rst_req & state_ff.trip[t] & (auto_dem[t] | state_ff.demand[t]);

			// Each train drives only its own breaker coils
			nxt_state.hold[t] = ~nxt_state.trip[t];
			nxt_state.shunt[t] = nxt_state.trip[t];
		end

		nxt_state.turb = |nxt_state.trip;
		nxt_state.annunc = |nxt_state.chan_byp;

		// Sticky events, a new event wins over a same-cycle clear
		if (tcv_wr_hit(wr_en, avs_address, tcv_pkg::REG_IRQ_STAT)) begin
			irq_clr = avs_writedata[3:0];
		end
		for (int b = 0; b < 4; b++) begin
			if (irq_ev[b]) begin
				nxt_state.irq_stat[b] = 1'b1;
			end else if (irq_clr[b]) begin
				nxt_state.irq_stat[b] = 1'b0;
			end
		end
		nxt_state.irq_out = |(nxt_state.irq_stat & nxt_state.irq_mask);

		status_word = 32'h0;
		status_word[tcv_pkg::ST_TRIP_POS +: 2] = state_ff.trip;
		status_word[tcv_pkg::ST_LO_BYP_POS +: 2] = state_ff.lo_byp;
		status_word[tcv_pkg::ST_IR_BLK_POS +: 2] = state_ff.ir_blk;
		status_word[tcv_pkg::ST_SR_BYP_POS +: 2] = sr_eff_byp;
		status_word[tcv_pkg::ST_P10_POS +: 2] = p10;
		status_word[tcv_pkg::ST_P6_POS +: 2] = p6;
		status_word[tcv_pkg::ST_DEMAND_POS +: 2] = state_ff.demand;

		// Read data captured in the wait cycle
		if (avs_read && !state_ff.ack) begin
			case (avs_address)
				tcv_pkg::REG_CMD: begin
					// Command word is write-only pulses
					nxt_state.rdata = 32'h0;
				end
				tcv_pkg::REG_CHAN_BYP: begin
					nxt_state.rdata = {28'h0, state_ff.chan_byp};
				end
				tcv_pkg::REG_STATUS: begin
					nxt_state.rdata = status_word;
				end
				tcv_pkg::REG_IRQ_STAT: begin
					nxt_state.rdata = {28'h0, state_ff.irq_stat};
				end
				tcv_pkg::REG_IRQ_MASK: begin
					nxt_state.rdata = {28'h0, state_ff.irq_mask};
				end
				default: begin
					nxt_state.rdata = 32'h0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_ff.ack <= 1'b0;
			state_ff.rdata <= tcv_pkg::RST_RDATA;
			state_ff.chan_byp <= tcv_pkg::RST_CHAN_BYP;
			state_ff.irq_stat <= 4'h0;
			state_ff.irq_mask <= tcv_pkg::RST_IRQ_MASK;
			state_ff.lo_byp <= 2'h0;
			state_ff.ir_blk <= 2'h0;
			state_ff.sr_byp <= 2'h0;
			state_ff.demand <= 2'h0;
			state_ff.trip <= tcv_pkg::RST_TRIP;
			state_ff.hold <= ~tcv_pkg::RST_TRIP;
			state_ff.shunt <= tcv_pkg::RST_TRIP;
			state_ff.turb <= 1'b1;
			state_ff.annunc <= 1'b0;
			state_ff.irq_out <= 1'b0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign avs_waitrequest = req & ~state_ff.ack;
	assign avs_readdata = state_ff.rdata;
	assign irq = state_ff.irq_out;
	assign train_a_trip_breaker_uv_hold = state_ff.hold[0];
	assign train_a_trip_breaker_shunt = state_ff.shunt[0];
	assign train_b_trip_breaker_uv_hold = state_ff.hold[1];
	assign train_b_trip_breaker_shunt = state_ff.shunt[1];
	assign turbine_trip = state_ff.turb;
	assign chan_bypass_annunc = state_ff.annunc;

endmodule
`default_nettype wire

// ---- tcv_monitor.sv ----
// Checker for the voter's breaker, turbine and bus outputs.
// Assumes it is bound to tcv_voter and sees only its ports.
`default_nettype none
module tcv_monitor (
	input wire logic        sys_clk,
	input wire logic        sys_rst,
	input wire logic [2:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic        avs_waitrequest,
	input wire logic        irq,
	input wire logic [7:0]  pr_high_bist,
	input wire logic [7:0]  pr_rate_bist,
	input wire logic        train_a_trip_breaker_uv_hold,
	input wire logic        train_a_trip_breaker_shunt,
	input wire logic        train_b_trip_breaker_uv_hold,
	input wire logic        train_b_trip_breaker_shunt,
	input wire logic        turbine_trip
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	logic cmd;
	assign cmd = avs_write && !avs_waitrequest && avs_address == tcv_pkg::REG_CMD;
	coil_pair_a: assert property (train_a_trip_breaker_uv_hold != train_a_trip_breaker_shunt)
		else $error("train a coils agree");
	coil_pair_b_a: assert property (train_b_trip_breaker_uv_hold != train_b_trip_breaker_shunt)
		else $error("train b coils agree");
	turbine_follow_a: assert property (turbine_trip == (train_a_trip_breaker_shunt | train_b_trip_breaker_shunt))
		else $error("turbine trip mismatch");
	high_flux_a: assert property ($countones(pr_high_bist[3:0]) > 1 |-> ##2 train_a_trip_breaker_shunt)
		else $error("train a high flux missed");
	high_flux_b_a: assert property ($countones(pr_high_bist[7:4]) > 1 |-> ##2 train_b_trip_breaker_shunt)
		else $error("train b high flux missed");
	flux_rate_a: assert property ($countones(pr_rate_bist[7:4]) > 1 |-> ##2 train_b_trip_breaker_shunt)
		else $error("flux rate trip missed");
	manual_trip_a: assert property (cmd && avs_writedata[9] |-> ##2 train_b_trip_breaker_shunt)
		else $error("manual trip missed");
	trip_latch_a: assert property ($fell(train_a_trip_breaker_shunt) |-> $past(cmd) || $past(cmd, 2))
		else $error("trip released without reset");
	bus_wait_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("bus wait cycle wrong");
	cover property ($fell(train_a_trip_breaker_shunt));
	cover property ($rose(irq));
	cover property ($fell(turbine_trip));
endmodule
bind tcv_voter tcv_monitor mon_u (.sys_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
	.avs_waitrequest, .irq, .pr_high_bist, .pr_rate_bist, .train_a_trip_breaker_uv_hold,
	.train_a_trip_breaker_shunt, .train_b_trip_breaker_uv_hold, .train_b_trip_breaker_shunt, .turbine_trip);
`default_nettype wire

// ---- tcv_chan_model.sv ----
// Far-side model: analog channel bistables, fanned out to both trains.
// Assumes the bench sets channel states by non-blocking assignment.
`default_nettype none
module tcv_chan_model (
	input  wire logic [21:0] ch,
	output logic      [7:0]  pr_high_bist,
	output logic      [7:0]  pr_low_bist,
	output logic      [7:0]  pr_rate_bist,
	output logic      [7:0]  pr_p10_bist,
	output logic      [3:0]  ir_trip_bist,
	output logic      [3:0]  ir_p6_bist,
	output logic      [3:0]  sr_trip_bist
);
	timeunit 1ns;
	timeprecision 1ns;
	assign pr_high_bist = {2{ch[3:0]}};
	assign pr_low_bist  = {2{ch[7:4]}};
	assign pr_rate_bist = {2{ch[11:8]}};
	assign pr_p10_bist  = {2{ch[15:12]}};
	assign ir_trip_bist = {2{ch[17:16]}};
	assign ir_p6_bist   = {2{ch[19:18]}};
	assign sr_trip_bist = {2{ch[21:20]}};
endmodule
`default_nettype wire

// ---- tcv_voter_tb.sv ----
// Bench for the trip voter: bus reads are scored against queued notes.
// Assumes tcv_chan_model feeds the bistables of both trains.
`default_nettype none
module tcv_voter_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        sys_clk = 1'h0;
	logic        sys_rst = 1'h1;
	logic [2:0]  avs_address = 3'h0;
	logic        avs_read = 1'h0;
	logic        avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [21:0] ch = 22'h0;
	logic [31:0] rdat;
	logic        wt, irq, ann, turb, ua, sa, ub, sb;
	logic [7:0]  hb, lb, rb, pb;
	logic [3:0]  ib, p6b, srb;
	logic [77:0] q[$];
	logic [77:0] n;
	int          fail_count = 0;
	int          num_checks = 0;
	int          k;
	wire  [38:0] seen = {irq, ann, turb, sb, ub, sa, ua, rdat};
	always #5 sys_clk = ~sys_clk;
	tcv_chan_model far_u (.ch(ch), .pr_high_bist(hb), .pr_low_bist(lb), .pr_rate_bist(rb), .pr_p10_bist(pb),
		.ir_trip_bist(ib), .ir_p6_bist(p6b), .sr_trip_bist(srb));
	tcv_voter dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(rdat), .avs_waitrequest(wt),
		.irq(irq), .pr_high_bist(hb), .pr_low_bist(lb), .pr_rate_bist(rb), .pr_p10_bist(pb),
		.ir_trip_bist(ib), .ir_p6_bist(p6b), .sr_trip_bist(srb), .train_a_trip_breaker_uv_hold(ua),
		.train_a_trip_breaker_shunt(sa), .train_b_trip_breaker_uv_hold(ub), .train_b_trip_breaker_shunt(sb),
		.turbine_trip(turb), .chan_bypass_annunc(ann));
	task automatic chk(input logic [38:0] s, input logic [38:0] e);
		num_checks++;
		if (s !== e) begin
			fail_count++;
			$display("wrong value outputs: expected %h seen %h", e, s);
		end
	endtask
	task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		avs_write <= w;
		avs_read <= !w;
		avs_address <= a;
		avs_writedata <= d;
		do @(posedge sys_clk); while (wt !== 1'h0);
		avs_write <= 1'h0;
		avs_read <= 1'h0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [38:0] m, input logic [38:0] e);
		repeat (3) @(posedge sys_clk);
		q.push_back({m, e});
		bus(1'h0, a, 32'h0);
	endtask
	// Trip state t per train plus status bypass field b
	task automatic sts(input logic [1:0] t, input logic [5:0] b);
		rd(tcv_pkg::REG_STATUS, 39'h1F_0000_00FF, {2'h0, |t, t[1], !t[1], t[0], !t[0], 24'h0, b, t});
	endtask
	task automatic clr();
		ch <= 22'h0;
		repeat (3) @(posedge sys_clk);
		bus(1'h1, tcv_pkg::REG_CMD, 32'hC00);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		if (avs_read && wt === 1'h0) begin
			n = q.pop_front();
			chk(seen & n[77:39], n[38:0]);
		end
	end
	initial begin
		#40000;
		fail_count++;
		print_verdict();
	end
	initial begin
		k = $urandom(32'hD6E1);
		repeat (16) @(posedge sys_clk);
		sys_rst <= 1'h0;
		sts(2'h3, 6'h0);
		rd(tcv_pkg::REG_CHAN_BYP, 39'h0_FFFF_FFFF, 39'h0);
		rd(tcv_pkg::REG_IRQ_MASK, 39'h0_FFFF_FFFF, 39'h0);
		rd(3'h5, 39'h0_FFFF_FFFF, 39'h0);
		bus(1'h1, tcv_pkg::REG_IRQ_MASK, 32'hF);
		clr();
		sts(2'h0, 6'h0);
		k = $urandom % 4;
		ch[3:0] <= 4'h1 << k;
		sts(2'h0, 6'h0);
		ch[3:0] <= (4'h1 << k) | (4'h1 << ((k + 1 + $urandom % 3) % 4));
		sts(2'h3, 6'h0);
		rd(tcv_pkg::REG_IRQ_STAT, 39'h40_0000_000F, {7'h40, 32'h3});
		bus(1'h1, tcv_pkg::REG_CMD, 32'hC00);
		rd(tcv_pkg::REG_IRQ_STAT, 39'h40_0000_000F, {7'h40, 32'hF});
		sts(2'h3, 6'h0);
		bus(1'h1, tcv_pkg::REG_IRQ_STAT, 32'hF);
		rd(tcv_pkg::REG_IRQ_STAT, 39'h40_0000_000F, 39'h0);
		clr();
		bus(1'h1, tcv_pkg::REG_CMD, 32'hF);
		sts(2'h0, 6'h0);
		ch[15:12] <= 4'h6;
		bus(1'h1, tcv_pkg::REG_CMD, 32'hF);
		ch[7:4] <= 4'hF;
		ch[17:16] <= 2'h3;
		ch[21:20] <= 2'h3;
		sts(2'h0, 6'h3F);
		ch[15:12] <= 4'h4;
		sts(2'h3, 6'h0);
		clr();
		bus(1'h1, tcv_pkg::REG_CHAN_BYP, 32'h5);
		ch[16] <= 1'h1;
		ch[20] <= 1'h1;
		rd(tcv_pkg::REG_CHAN_BYP, 39'h20_FFFF_FFFF, {7'h20, 32'h5});
		sts(2'h0, 6'h0);
		ch[17] <= 1'h1;
		sts(2'h3, 6'h0);
		bus(1'h1, tcv_pkg::REG_CHAN_BYP, 32'h0);
		clr();
		ch[19:18] <= 2'h2;
		bus(1'h1, tcv_pkg::REG_CMD, 32'h30);
		bus(1'h1, tcv_pkg::REG_CMD, 32'h40);
		ch[21] <= 1'h1;
		sts(2'h1, 6'h20);
		ch[19:18] <= 2'h0;
		sts(2'h3, 6'h0);
		clr();
		ch[11:8] <= 4'h9;
		sts(2'h3, 6'h0);
		clr();
		bus(1'h1, tcv_pkg::REG_CMD, 32'h200);
		sts(2'h2, 6'h0);
		clr();
		sts(2'h0, 6'h0);
		print_verdict();
	end
endmodule
`default_nettype wire
